/* src/peo_consts.svh */
// named constants for the privilege, byte-order and operand convention unit
`ifndef PEO_CONSTS_SVH
`define PEO_CONSTS_SVH

`define PEO_NUM_REGS     32
`define PEO_GR_WIDTH     32
`define PEO_FR_WIDTH     64
`define PEO_INSTR_WIDTH  32

// instruction word fields
`define PEO_F_OP_HI      31
`define PEO_F_OP_LO      26
`define PEO_F_RT_HI      25
`define PEO_F_RT_LO      21
`define PEO_F_RA_HI      20
`define PEO_F_RA_LO      16
`define PEO_F_RB_HI      15
`define PEO_F_RB_LO      11
`define PEO_F_IMM_HI     15
`define PEO_F_IMM_LO     0
`define PEO_F_TBSEL      11

// opcodes; loads and stores carry the operand size in op[1:0]
`define PEO_OP_ADD       6'h01
`define PEO_OPGRP_LOAD   4'h2
`define PEO_OPGRP_STORE  4'h3
`define PEO_OP_FMR       6'h10
`define PEO_OP_FRSP      6'h11
`define PEO_OP_MFTB      6'h14
`define PEO_OP_MTTB      6'h15
`define PEO_OP_MFMSR     6'h18
`define PEO_OP_MTMSR     6'h19
`define PEO_OP_RFX       6'h1A
`define PEO_OP_SC        6'h1B

// operand sizes
`define PEO_SZ_BYTE      2'h0
`define PEO_SZ_HALF      2'h1
`define PEO_SZ_WORD      2'h2
`define PEO_SZ_DOUBLE    2'h3

// machine state register
`define PEO_MSR_LE_BIT   0
`define PEO_MSR_PR_BIT   14
`define PEO_MSR_ILE_BIT  16
`define PEO_MSR_RESET    32'h0000_0000
`define PEO_MSR_WMASK    32'h0001_4001

// exception causes
`define PEO_EXC_EXT      2'h0
`define PEO_EXC_PRIV     2'h1
`define PEO_EXC_SC       2'h2
`define PEO_EXC_ILLEGAL  2'h3

// double to single rounding: mantissa bits below this are dropped
`define PEO_DP_KEEP_LO   29
`define PEO_DP_GUARD     28

`endif

/* src/peo_core_rules.sv */
// privilege, byte-order and operand convention unit of a 32-bit core
//
// Overview of operation
// - supervisor-level resources are reachable only in supervisor state, never from user state.
// - instructions that change machine state, translation or supervisor registers run only in supervisor state.
// - 32 general and 32 float registers exist and are open to both privilege levels.
// - the time base is two 32-bit registers, readable by both levels, writable only by supervisor.
// - big-endian is the default ordering and little-endian is a selectable option.
// - byte_order_select 0 means big-endian and 1 little-endian, and exception_byte_order uses the same code.
// - on taking an exception, exception_byte_order is copied into byte_order_select.
// - memory is byte addressed from 0, each number being the address of its byte.
// - a multi-byte operand is addressed by its lowest byte and its length comes from the instruction.
// - a single-register operand is aligned when its address is a multiple of its length, else misaligned.
// - double-precision operations take either precision and always give a double result.
// - single-precision results are kept in double format, rounded to fit the 32-bit single format; the code does not clamp the exponent.
// - every instruction is one fixed-format 32-bit word decoded alongside the operand reads.
`timescale 1ns/10ps
`include "peo_consts.svh"
module peo_core_rules (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        instr_valid_in,
  input  wire logic [`PEO_INSTR_WIDTH-1:0] instr_word_in,
  output logic                             instr_ready_out,
  input  wire logic                        exception_in,
  input  wire logic [`PEO_FR_WIDTH-1:0]    mem_rdata_in,
  input  wire logic                        mem_rvalid_in,
  output logic                             mem_req_out,
  output logic                             mem_we_out,
  output logic [31:0]                      mem_addr_out,
  output logic [1:0]                       mem_size_out,
  output logic [`PEO_FR_WIDTH-1:0]         mem_wdata_out,
  output logic [31:0]                      msr_out,
  output logic                             user_mode_out,
  output logic                             little_endian_out,
  output logic                             exc_taken_out,
  output logic [1:0]                       exc_cause_out,
  output logic                             misaligned_out,
  output logic                             result_valid_out,
  output logic [`PEO_FR_WIDTH-1:0]         result_out
);

  // lane j of the data bus carries the byte at address addr+j
  function automatic logic [63:0] peo_order(input logic [63:0] d,
                                            input logic [1:0]  sz,
                                            input logic        le);
    logic [63:0] r;
    int          n;
    r = '0;
    n = 1 << sz;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        r[8*i +: 8] = le ? d[8*i +: 8] : d[8*(n-1-i) +: 8];
      end
    end
    return r;
  endfunction : peo_order

  peo_pkg::peo_state_t state_r;
  logic [31:0]         msr_r;
  logic [31:0]         saved_msr_r;
  logic [31:0]         tb_upper_r;
  logic [31:0]         tb_lower_r;
  logic [4:0]          load_dest_r;
  peo_pkg::peo_size_t  load_size_r;
  logic                load_le_r;

  // fixed fields let register reads start before decode finishes
  logic [5:0]  op;
  logic [4:0]  rt;
  logic [4:0]  ra;
  logic [4:0]  rb;
  logic [31:0] imm_sext;
  assign op       = instr_word_in[`PEO_F_OP_HI:`PEO_F_OP_LO];
  assign rt       = instr_word_in[`PEO_F_RT_HI:`PEO_F_RT_LO];
  assign ra       = instr_word_in[`PEO_F_RA_HI:`PEO_F_RA_LO];
  assign rb       = instr_word_in[`PEO_F_RB_HI:`PEO_F_RB_LO];
  assign imm_sext = {{16{instr_word_in[`PEO_F_IMM_HI]}},
                     instr_word_in[`PEO_F_IMM_HI:`PEO_F_IMM_LO]};

  logic [31:0] gr_a;
  logic [31:0] gr_b;
  logic [63:0] fr_a;
  logic [63:0] fr_t;
  logic        gr_we;
  logic [4:0]  gr_waddr;
  logic [31:0] gr_wdata;
  logic        fr_we;
  logic [4:0]  fr_waddr;
  logic [63:0] fr_wdata;

  peo_regfile #(.WIDTH(`PEO_GR_WIDTH)) u_general_registers (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .we_in       (gr_we),
    .waddr_in    (gr_waddr),
    .wdata_in    (gr_wdata),
    .raddr_a_in  (ra),
    .raddr_b_in  (rb),
    .rdata_a_out (gr_a),
    .rdata_b_out (gr_b)
  );

  peo_regfile #(.WIDTH(`PEO_FR_WIDTH)) u_float_registers (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .we_in       (fr_we),
    .waddr_in    (fr_waddr),
    .wdata_in    (fr_wdata),
    .raddr_a_in  (ra),
    .raddr_b_in  (rt),
    .rdata_a_out (fr_a),
    .rdata_b_out (fr_t)
  );

  // decode
  logic        user;
  logic        go;
  logic        is_load;
  logic        is_store;
  logic        is_priv;
  logic        is_known;
  logic        priv_fault;
  logic        illegal;
  logic        sys_call;
  logic        take_exc;
  logic        ls_size_dbl;
  logic [31:0] ea;
  logic        misal;
  logic        mem_go;

  assign user     = msr_r[`PEO_MSR_PR_BIT];
  assign go       = instr_valid_in && instr_ready_out && !exception_in;
  assign is_load  = (op[5:2] == `PEO_OPGRP_LOAD);
  assign is_store = (op[5:2] == `PEO_OPGRP_STORE);
  assign is_priv  = (op == `PEO_OP_MTTB) || (op == `PEO_OP_MFMSR) ||
                    (op == `PEO_OP_MTMSR) || (op == `PEO_OP_RFX);
  assign is_known = is_load || is_store || is_priv || (op == `PEO_OP_ADD) ||
                    (op == `PEO_OP_FMR) || (op == `PEO_OP_FRSP) ||
                    (op == `PEO_OP_MFTB) || (op == `PEO_OP_SC);
  assign priv_fault = go && is_priv && user;
  assign illegal    = go && !is_known;
  assign sys_call   = go && (op == `PEO_OP_SC);
  assign take_exc   = exception_in || priv_fault || illegal || sys_call;
  assign ls_size_dbl = (op[1:0] == `PEO_SZ_DOUBLE);

  // byte address of the lowest byte of the operand
  assign ea = gr_a + imm_sext;

  always_comb begin
    unique case (op[1:0])
      `PEO_SZ_BYTE: misal = 1'b0;
      `PEO_SZ_HALF: misal = ea[0];
      `PEO_SZ_WORD: misal = |ea[1:0];
      `PEO_SZ_DOUBLE: misal = |ea[2:0];
    endcase
  end
  // misaligned accesses are refused rather than split into pieces
  assign mem_go = go && (is_load || is_store) && !misal;

  // round double to nearest-even single precision, kept in double format
  logic [63:0] frsp_val;
  logic        rnd_up;
  logic [33:0] exp_mant;
  assign rnd_up   = fr_a[`PEO_DP_GUARD] &&
                    ((|fr_a[`PEO_DP_GUARD-1:0]) || fr_a[`PEO_DP_KEEP_LO]);
  // a carry out of the mantissa bumps the exponent; no range clamping done
  assign exp_mant = fr_a[62:`PEO_DP_KEEP_LO] + {33'h0_0000_0000, rnd_up};
  assign frsp_val = {fr_a[63], exp_mant, {`PEO_DP_KEEP_LO{1'b0}}};

  logic [63:0] load_val;
  assign load_val = peo_order(mem_rdata_in, load_size_r, load_le_r);

  // register writes: loads return only in the wait state, so no port clash
  always_comb begin
    gr_we    = 1'b0;
    gr_waddr = rt;
    gr_wdata = '0;
    fr_we    = 1'b0;
    fr_waddr = rt;
    fr_wdata = '0;
    if (state_r == peo_pkg::peo_st_wait) begin
      if (mem_rvalid_in) begin
        if (load_size_r == `PEO_SZ_DOUBLE) begin
          fr_we    = 1'b1;
          fr_waddr = load_dest_r;
          fr_wdata = load_val;
        end else begin
          gr_we    = 1'b1;
          gr_waddr = load_dest_r;
          gr_wdata = load_val[31:0];
        end
      end
    end else if (go && !take_exc) begin
      unique case (op)
        `PEO_OP_ADD: begin
          gr_we    = 1'b1;
          gr_wdata = gr_a + gr_b;
        end
        `PEO_OP_FMR: begin
          fr_we    = 1'b1;
          fr_wdata = fr_a;
        end
        `PEO_OP_FRSP: begin
          fr_we    = 1'b1;
          fr_wdata = frsp_val;
        end
        `PEO_OP_MFTB: begin
          gr_we    = 1'b1;
          gr_wdata = instr_word_in[`PEO_F_TBSEL] ? tb_upper_r : tb_lower_r;
        end
        `PEO_OP_MFMSR: begin
          gr_we    = 1'b1;
          gr_wdata = msr_r;
        end
        default: begin
          gr_we = 1'b0;
        end
      endcase
    end
  end

  // load tracking
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r         <= peo_pkg::peo_st_run;
      instr_ready_out <= 1'b0;
      load_dest_r     <= '0;
      load_size_r     <= `PEO_SZ_BYTE;
      load_le_r       <= 1'b0;
    end else if (state_r == peo_pkg::peo_st_wait) begin
      if (mem_rvalid_in) begin
        state_r         <= peo_pkg::peo_st_run;
        instr_ready_out <= 1'b1;
      end
    end else begin
      instr_ready_out <= 1'b1;
      if (mem_go && is_load) begin
        state_r         <= peo_pkg::peo_st_wait;
        instr_ready_out <= 1'b0;
        load_dest_r     <= rt;
        load_size_r     <= op[1:0];
        load_le_r       <= msr_r[`PEO_MSR_LE_BIT];
      end
    end
  end

  // machine state and exception entry
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      msr_r         <= `PEO_MSR_RESET;
      saved_msr_r   <= `PEO_MSR_RESET;
      exc_taken_out <= 1'b0;
      exc_cause_out <= `PEO_EXC_EXT;
    end else begin
      exc_taken_out <= take_exc;
      if (take_exc) begin
        saved_msr_r <= msr_r;
        msr_r[`PEO_MSR_PR_BIT] <= 1'b0;
        msr_r[`PEO_MSR_LE_BIT] <= msr_r[`PEO_MSR_ILE_BIT];
        if (exception_in) begin
          exc_cause_out <= `PEO_EXC_EXT;
        end else if (priv_fault) begin
          exc_cause_out <= `PEO_EXC_PRIV;
        end else if (sys_call) begin
          exc_cause_out <= `PEO_EXC_SC;
        end else begin
          exc_cause_out <= `PEO_EXC_ILLEGAL;
        end
      end else if (go && (op == `PEO_OP_MTMSR)) begin
        msr_r <= gr_a & `PEO_MSR_WMASK;
      end else if (go && (op == `PEO_OP_RFX)) begin
        msr_r <= saved_msr_r;
      end
    end
  end

  // time base: counts every clock except one with a supervisor write, which replaces one half
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tb_upper_r <= '0;
      tb_lower_r <= '0;
    end else if (go && !take_exc && (op == `PEO_OP_MTTB)) begin
      if (instr_word_in[`PEO_F_TBSEL]) begin
        tb_upper_r <= gr_a;
      end else begin
        tb_lower_r <= gr_a;
      end
    end else begin
      {tb_upper_r, tb_lower_r} <= 64'({tb_upper_r, tb_lower_r} + 64'h1);
    end
  end

  // memory request, one cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      mem_req_out    <= 1'b0;
      mem_we_out     <= 1'b0;
      mem_addr_out   <= '0;
      mem_size_out   <= `PEO_SZ_BYTE;
      mem_wdata_out  <= '0;
      misaligned_out <= 1'b0;
    end else begin
      mem_req_out    <= mem_go;
      mem_we_out     <= mem_go && is_store;
      misaligned_out <= go && (is_load || is_store) && misal;
      if (mem_go) begin
        mem_addr_out  <= ea;
        mem_size_out  <= op[1:0];
        mem_wdata_out <= peo_order(ls_size_dbl ? fr_t : {32'h0000_0000, gr_b},
                                   op[1:0], msr_r[`PEO_MSR_LE_BIT]);
      end
    end
  end

  // result echo of every register write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result_valid_out <= 1'b0;
      result_out       <= '0;
    end else begin
      result_valid_out <= gr_we || fr_we;
      if (fr_we) begin
        result_out <= fr_wdata;
      end else if (gr_we) begin
        result_out <= {32'h0000_0000, gr_wdata};
      end
    end
  end

  // status mirrors
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      msr_out           <= `PEO_MSR_RESET;
      user_mode_out     <= 1'b0;
      little_endian_out <= 1'b0;
    end else begin
      msr_out           <= msr_r;
      user_mode_out     <= msr_r[`PEO_MSR_PR_BIT];
      little_endian_out <= msr_r[`PEO_MSR_LE_BIT];
    end
  end
endmodule : peo_core_rules

/* src/peo_pkg.sv */
// types shared by the convention unit
package peo_pkg;
  typedef enum logic [0:0] {
    peo_st_run  = 1'b0,
    peo_st_wait = 1'b1
  } peo_state_t;

  typedef logic [1:0] peo_size_t;
endpackage : peo_pkg

/* src/peo_regfile.sv */
// 32-entry register array, two read ports, one write port
`timescale 1ns/10ps
`include "peo_consts.svh"
module peo_regfile #(
  parameter int WIDTH = `PEO_GR_WIDTH
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             we_in,
  input  wire logic [4:0]       waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [4:0]       raddr_a_in,
  input  wire logic [4:0]       raddr_b_in,
  output logic      [WIDTH-1:0] rdata_a_out,
  output logic      [WIDTH-1:0] rdata_b_out
);
  logic [WIDTH-1:0] regs_r [`PEO_NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < `PEO_NUM_REGS; g++) begin : g_entry
      always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          regs_r[g] <= '0;
        end else if (we_in && (waddr_in == 5'(g))) begin
          regs_r[g] <= wdata_in;
        end
      end
    end
  endgenerate

  assign rdata_a_out = regs_r[raddr_a_in];
  assign rdata_b_out = regs_r[raddr_b_in];
endmodule : peo_regfile

/* tb/peo_core_rules_checker.sv */
// port assertions for the convention unit
`timescale 1ns/10ps
module peo_core_rules_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        instr_valid_in,
  input wire logic [31:0] instr_word_in,
  input wire logic        instr_ready_out,
  input wire logic        exception_in,
  input wire logic        mem_rvalid_in,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [1:0]  mem_size_out,
  input wire logic        misaligned_out,
  input wire logic [31:0] msr_out,
  input wire logic        user_mode_out,
  input wire logic        exc_taken_out,
  input wire logic [1:0]  exc_cause_out,
  input wire logic        result_valid_out
);
  logic       take;
  logic [5:0] op;
  assign take = instr_valid_in && instr_ready_out && !exception_in;
  assign op   = instr_word_in[31:26];
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  aligned_req_a: assert property (mem_req_out |->
    (mem_addr_out & ((32'h1 << mem_size_out) - 32'h1)) == 32'h0) else $error("unaligned request");
  mis_no_req_a: assert property (misaligned_out |-> !mem_req_out)
    else $error("misaligned access reached memory");
  load_return_a: assert property (mem_rvalid_in && !instr_ready_out |=> result_valid_out)
    else $error("load return not written");
  load_stall_a: assert property (mem_req_out && !mem_we_out |-> !instr_ready_out)
    else $error("ready during load");
  ext_exc_a: assert property ($rose(exception_in) && instr_ready_out |=>
    exc_taken_out && exc_cause_out == 2'h0) else $error("external exception missed");
  exc_entry_a: assert property (exc_taken_out |=>
    !msr_out[14] && msr_out[0] == msr_out[16]) else $error("bad state after exception");
  priv_trap_a: assert property (take && user_mode_out && !exc_taken_out
    && !$past(exc_taken_out) && (op == 6'h15 || op == 6'h18 || op == 6'h19 || op == 6'h1A)
    |=> exc_taken_out && exc_cause_out == 2'h1) else $error("privileged op not trapped");
  user_tb_read_a: assert property (take && user_mode_out && !exc_taken_out
    && !$past(exc_taken_out) && op == 6'h14 |=> result_valid_out && !exc_taken_out)
    else $error("user time base read refused");
  add_result_a: assert property (take && op == 6'h01 |=> result_valid_out && !exc_taken_out)
    else $error("add gave no result");
  sc_cause_a: assert property (take && op == 6'h1B |=> exc_taken_out && exc_cause_out == 2'h2)
    else $error("system call cause wrong");
endmodule : peo_core_rules_checker

bind peo_core_rules peo_core_rules_checker u_chk (
  .sys_clk_in, .rst_n_in, .instr_valid_in, .instr_word_in, .instr_ready_out, .exception_in,
  .mem_rvalid_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_size_out, .misaligned_out,
  .msr_out, .user_mode_out, .exc_taken_out, .exc_cause_out, .result_valid_out
);

/* tb/peo_core_rules_tb_top.sv */
// self-checking bench for the convention unit
`timescale 1ns/10ps
module peo_core_rules_tb_top;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        instr_valid_in = 1'b0;
  logic [31:0] instr_word_in = 32'h0;
  logic        exception_in = 1'b0;
  logic [63:0] mem_rdata_in = 64'h0;
  logic        mem_rvalid_in = 1'b0;
  logic        instr_ready_out, mem_req_out, mem_we_out, user_mode_out, little_endian_out;
  logic        exc_taken_out, misaligned_out, result_valid_out;
  logic [31:0] mem_addr_out, msr_out;
  logic [1:0]  mem_size_out, exc_cause_out;
  logic [63:0] mem_wdata_out, result_out;
  logic [63:0] exp_q[$];
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          seed = 17;

  peo_core_rules dut (
    .sys_clk_in, .rst_n_in, .instr_valid_in, .instr_word_in, .instr_ready_out, .exception_in,
    .mem_rdata_in, .mem_rvalid_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_size_out,
    .mem_wdata_out, .msr_out, .user_mode_out, .little_endian_out, .exc_taken_out,
    .exc_cause_out, .misaligned_out, .result_valid_out, .result_out
  );

  always #12.5 sys_clk_in = ~sys_clk_in;

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #2;
    end
  endtask : step

  function automatic logic [31:0] ins(logic [5:0] op, logic [4:0] rt, logic [4:0] ra,
                                      logic [15:0] lo);
    return {op, rt, ra, lo};
  endfunction : ins

  // one idle edge first so valid is never lowered and raised in one step
  task automatic issue(input logic [31:0] w);
    step(1);
    instr_word_in = w;
    instr_valid_in = 1'b1;
    while (instr_ready_out !== 1'b1) step(1);
    step(1);
    instr_valid_in = 1'b0;
  endtask : issue

  task automatic exc(input logic [31:0] w, input logic [1:0] c);
    issue(w);
    chk({exc_taken_out, exc_cause_out, result_valid_out}, {1'b1, c, 1'b0}, "exception");
  endtask : exc

  // base register is r0, which stays zero, so the address is the offset
  task automatic ld(input logic [4:0] rt, input logic [15:0] a, input logic [1:0] sz,
                    input logic le, input logic [63:0] d, output logic [63:0] v);
    v = 64'h0;
    for (int j = 0; j < (1 << sz); j++)
      v = le ? (v | (64'(d[8*j +: 8]) << (8 * j))) : ((v << 8) | 64'(d[8*j +: 8]));
    issue(ins({4'h2, sz}, rt, 5'h00, a));
    if ((a & ((16'h1 << sz) - 16'h1)) != 16'h0) begin
      chk({misaligned_out, mem_req_out}, 2'h2, "refuse");
    end else begin
      chk({mem_req_out, mem_we_out, mem_addr_out, mem_size_out}, {2'h2, 16'h0, a, sz}, "req");
      chk(instr_ready_out, 1'b0, "stall");
      exp_q.push_back(v);
      step(1 + ($random(seed) & 3));
      mem_rdata_in = d;
      mem_rvalid_in = 1'b1;
      step(1);
      mem_rvalid_in = 1'b0;
      mem_rdata_in = ~d;
      step(1);
    end
  endtask : ld

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  // every register write must have a note; an unexpected write counts
  always @(posedge sys_clk_in) begin
    if (rst_n_in && result_valid_out === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(result_out, exp_q.pop_front(), "result");
      end else begin
        total_checks++;
        error_cnt++;
        $display("Error at %0t: unexpected register write", $time);
      end
    end
  end

  initial begin
    logic [63:0] r, v1, v2, vd;
    logic [5:0]  pop [4];
    pop = '{6'h15, 6'h18, 6'h19, 6'h1A};
    step(20);
    rst_n_in = 1'b1;
    step(2);
    chk({msr_out, user_mode_out, little_endian_out}, 34'h0, "reset mode");
    for (int s = 0; s < 4; s++) begin
      ld(5'(s + 4), 16'(8 * s + 8), 2'(s), 1'b0, {$random(seed), $random(seed)}, r);
      if (s > 0)
        ld(5'h09, 16'h0100 + 16'(1 + $unsigned($random(seed)) % ((1 << s) - 1)), 2'(s), 1'b0,
           64'h0, r);
    end
    ld(5'h01, 16'h0040, 2'h2, 1'b0, {$random(seed), $random(seed)}, v1);
    ld(5'h02, 16'h0044, 2'h2, 1'b0, {$random(seed), $random(seed)}, v2);
    ld(5'h07, 16'h0048, 2'h2, 1'b0, 64'h0000_0000_0140_0100, r);
    ld(5'h08, 16'h004C, 2'h2, 1'b0, 64'h0000_0000_0100_0000, r);
    r = v1 + v2;
    exp_q.push_back({32'h0, r[31:0]});
    issue(ins(6'h01, 5'h1F, 5'h01, {5'h02, 11'h000}));
    // store data comes from the register named in imm[15:11]: r1 here
    issue(ins(6'h0E, 5'h00, 5'h00, 16'h0804));
    chk({mem_req_out, mem_we_out, mem_addr_out, mem_size_out, instr_ready_out},
        {2'h3, 32'h0000_0804, 2'h2, 1'b1}, "store req");
    chk(mem_wdata_out, {32'h0, v1[7:0], v1[15:8], v1[23:16], v1[31:24]}, "store be");
    ld(5'h05, 16'h0080, 2'h3, 1'b0, {$random(seed), $random(seed)}, vd);
    exp_q.push_back(vd);
    issue(ins(6'h10, 5'h06, 5'h05, 16'h0000));
    r = vd;
    if (vd[28] && (vd[29] || vd[27:0] != 28'h0)) r = r + 64'h2000_0000;
    r[28:0] = 29'h0;
    exp_q.push_back(r);
    issue(ins(6'h11, 5'h07, 5'h05, 16'h0000));
    issue(ins(6'h15, 5'h00, 5'h00, 16'h0000));
    issue(ins(6'h15, 5'h00, 5'h02, 16'h0800));
    exp_q.push_back({32'h0, v2[31:0]});
    issue(ins(6'h14, 5'h0A, 5'h00, 16'h0800));
    issue(ins(6'h19, 5'h00, 5'h07, 16'h0000));
    step(2);
    chk({msr_out, user_mode_out, little_endian_out}, {32'h0001_4001, 2'h3}, "msr");
    ld(5'h0B, 16'h0050, 2'h2, 1'b1, {$random(seed), $random(seed)}, r);
    issue(ins(6'h0E, 5'h00, 5'h00, 16'h0808));
    chk(mem_wdata_out, {32'h0, v1[31:0]}, "store le");
    exp_q.push_back({32'h0, v2[31:0]});
    issue(ins(6'h14, 5'h0A, 5'h00, 16'h0800));
    for (int k = 0; k < 4; k++) begin
      if (k > 0) issue(ins(6'h19, 5'h00, 5'h07, 16'h0000));
      step(2);
      exc(ins(pop[k], 5'h0C, 5'h01, 16'h0800), 2'h1);
      step(2);
      chk(msr_out, 32'h0001_0001, "entry");
    end
    exp_q.push_back({32'h0, v2[31:0]});
    issue(ins(6'h14, 5'h0A, 5'h00, 16'h0800));
    issue(ins(6'h19, 5'h00, 5'h08, 16'h0000));
    step(2);
    exception_in = 1'b1;
    step(1);
    exception_in = 1'b0;
    chk({exc_taken_out, exc_cause_out}, 3'h4, "external");
    step(2);
    chk({msr_out, little_endian_out}, 33'h0, "order copy");
    issue(ins(6'h1A, 5'h00, 5'h00, 16'h0000));
    step(2);
    chk(msr_out, 32'h0000_0001, "return");
    exc(ins(6'h1B, 5'h00, 5'h00, 16'h0000), 2'h2);
    exc(ins(6'h3F, 5'h00, 5'h00, 16'h0000), 2'h3);
    step(3);
    chk(64'(exp_q.size()), 64'h0, "pending");
    rst_n_in = 1'b0;
    step(1);
    chk({instr_ready_out, msr_out, little_endian_out, exc_taken_out}, 35'h0, "in reset");
    rst_n_in = 1'b1;
    step(2);
    chk({instr_ready_out, msr_out, little_endian_out}, {1'b1, 33'h0}, "reset again");
    summarize();
  end
endmodule : peo_core_rules_tb_top
